// ===== rtl/chan_code_path.sv
// One converter channel: holding registers and the output code latch.
// Assumes the SFR write strobe is one core clock wide.
`timescale 1ns/1ps
`include "conv_ctrl_cfg.svh"
module chan_code_path
  import conv_ctrl_pkg::*;
#(
  parameter int CODE_W = `CODE_W
)
(
  input  wire logic              i_mclk,
  input  wire logic              i_arst_n,
  input  wire logic              i_wr_low,
  input  wire logic              i_wr_high,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_mode8,
  input  wire logic              i_sync,
  input  wire logic              i_sync_rise,
  output logic      [7:0]        o_low,
  output logic      [7:0]        o_high,
  output logic      [CODE_W-1:0] o_code
);

  logic [7:0]        low_ff;
  logic [7:0]        high_ff;
  logic [CODE_W-1:0] code_ff;
  logic [7:0]        nxt_low;
  logic [7:0]        nxt_high;
  logic [CODE_W-1:0] nxt_code;
  logic [CODE_W-1:0] held_code;

  // Holding registers, then the code seen by the converter
  always_comb
  begin
    nxt_low  = i_wr_low  ? i_wdata : low_ff;
    nxt_high = i_wr_high ? i_wdata : high_ff;
    // 8-bit mode uses the low byte alone, scaled to full span
    if (i_mode8)
      held_code = {nxt_low, {`HIGH_NIBBLE_W{1'b0}}};
    else
      held_code = {nxt_high[`HIGH_NIBBLE_W-1:0], nxt_low};
    nxt_code = code_ff;
    // High write alone never moves the output
    if (i_sync && i_wr_low)
      nxt_code = held_code;
    else if (i_sync_rise)
      nxt_code = held_code;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      low_ff  <= `DATA_RESET;
      high_ff <= `DATA_RESET;
      code_ff <= '0;
    end
    else
    begin
      low_ff  <= nxt_low;
      high_ff <= nxt_high;
      code_ff <= nxt_code;
    end
  end

  assign o_low  = low_ff;
  assign o_high = high_ff;
  assign o_code = code_ff;

endmodule

// ===== rtl/conv_ctrl.sv
// Dual converter control: SFR decode, control register, channel paths.
// Assumes a core SFR port with one-cycle write strobe and read data
// registered one cycle after the read address is presented.
`timescale 1ns/1ps
`include "conv_ctrl_cfg.svh"
module conv_ctrl
  import conv_ctrl_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_arst_n,
  input  wire logic [7:0]           i_sfr_addr,
  input  wire logic                 i_sfr_wr,
  input  wire logic [7:0]           i_sfr_wdata,
  input  wire logic                 i_sfr_rd,
  output logic      [7:0]           o_sfr_rdata,
  output logic                      o_sfr_hit,
  output chan_drive_type            o_chan0,
  output chan_drive_type            o_chan1,
  output logic                      o_out_en_four,
  output logic                      o_out_en_five,
  output logic      [`NUM_CHAN-1:0] o_input_free
);

  logic [7:0]        control_ff;
  logic [7:0]        nxt_control;
  logic [7:0]        rdata_ff;
  logic [7:0]        nxt_rdata;
  logic              hit_ff;
  logic              nxt_hit;
  chan_drive_type    drv0_ff;
  chan_drive_type    drv1_ff;
  chan_drive_type    nxt_drv0;
  chan_drive_type    nxt_drv1;
  logic [1:0]        en_ff;
  logic [1:0]        nxt_en;
  logic [1:0]        free_ff;
  logic [1:0]        nxt_free;
  logic              sync_rise;
  logic [7:0]        chan_low  [`NUM_CHAN];
  logic [7:0]        chan_high [`NUM_CHAN];
  logic [`CODE_W-1:0] chan_code [`NUM_CHAN];
  logic [`NUM_CHAN-1:0] wr_low;
  logic [`NUM_CHAN-1:0] wr_high;

  // Shared address match, used for both read and write decode
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // Write strobes per data register
  always_comb
  begin
    wr_low  = '0;
    wr_high = '0;
    if (i_sfr_wr && addr_is(i_sfr_addr, `ADDR_CHAN0_LOW))
      wr_low[0] = 1'b1;
    else if (i_sfr_wr && addr_is(i_sfr_addr, `ADDR_CHAN0_HIGH))
      wr_high[0] = 1'b1;
    else if (i_sfr_wr && addr_is(i_sfr_addr, `ADDR_CHAN1_LOW))
      wr_low[1] = 1'b1;
    else if (i_sfr_wr && addr_is(i_sfr_addr, `ADDR_CHAN1_HIGH))
      wr_high[1] = 1'b1;
  end

  // Control register next value
  always_comb
  begin
    nxt_control = control_ff;
    if (i_sfr_wr && addr_is(i_sfr_addr, `ADDR_CONTROL))
      nxt_control = i_sfr_wdata;
  end

  // Transfer of held codes when sync goes from 0 to 1
  assign sync_rise = !control_ff[`BIT_SYNC] && nxt_control[`BIT_SYNC];

  // Identical channel paths, one per converter core
  genvar g;
  generate
    for (g = 0; g < `NUM_CHAN; g++)
    begin : g_chan
      chan_code_path #(
        .CODE_W (`CODE_W)
      ) u_path (
        .i_mclk      (i_mclk),
        .i_arst_n    (i_arst_n),
        .i_wr_low    (wr_low[g]),
        .i_wr_high   (wr_high[g]),
        .i_wdata     (i_sfr_wdata),
        .i_mode8     (control_ff[`BIT_MODE]),
        .i_sync      (control_ff[`BIT_SYNC]),
        .i_sync_rise (sync_rise),
        .o_low       (chan_low[g]),
        .o_high      (chan_high[g]),
        .o_code      (chan_code[g])
      );
    end
  endgenerate

  // Read mux; unmapped addresses answer zero with no hit
  always_comb
  begin
    nxt_rdata = 8'h00;
    nxt_hit   = 1'b0;
    if (!i_sfr_rd)
    begin
      nxt_rdata = 8'h00;
      nxt_hit   = 1'b0;
    end
    else if (addr_is(i_sfr_addr, `ADDR_CHAN0_LOW))
    begin
      nxt_rdata = chan_low[0];
      nxt_hit   = 1'b1;
    end
    else if (addr_is(i_sfr_addr, `ADDR_CHAN0_HIGH))
    begin
      nxt_rdata = chan_high[0];
      nxt_hit   = 1'b1;
    end
    else if (addr_is(i_sfr_addr, `ADDR_CHAN1_LOW))
    begin
      nxt_rdata = chan_low[1];
      nxt_hit   = 1'b1;
    end
    else if (addr_is(i_sfr_addr, `ADDR_CHAN1_HIGH))
    begin
      nxt_rdata = chan_high[1];
      nxt_hit   = 1'b1;
    end
    else if (addr_is(i_sfr_addr, `ADDR_CONTROL))
    begin
      nxt_rdata = control_ff;
      nxt_hit   = 1'b1;
    end
  end

  // Drive toward the cores; registered so outputs come from flops
  always_comb
  begin
    nxt_drv0.code         = chan_code[0];
    nxt_drv0.span_supply  = control_ff[`BIT_SPAN0];
    nxt_drv0.zero_force_n = control_ff[`BIT_ZERO0_N];
    nxt_drv0.power_on     = control_ff[`BIT_POWER0];
    nxt_drv1.code         = chan_code[1];
    nxt_drv1.span_supply  = control_ff[`BIT_SPAN1];
    nxt_drv1.zero_force_n = control_ff[`BIT_ZERO1_N];
    nxt_drv1.power_on     = control_ff[`BIT_POWER1];
    // Powered-down channel leaves its shared pin to the input mux
    nxt_en = {control_ff[`BIT_POWER1], control_ff[`BIT_POWER0]};
    // Own flop for the free flags so the port needs no gate after a register
    nxt_free = ~nxt_en;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      control_ff <= `CONTROL_RESET;
      rdata_ff   <= 8'h00;
      hit_ff     <= 1'b0;
      drv0_ff    <= '0;
      drv1_ff    <= '0;
      en_ff      <= '0;
      free_ff    <= '1;
    end
    else
    begin
      control_ff <= nxt_control;
      rdata_ff   <= nxt_rdata;
      hit_ff     <= nxt_hit;
      drv0_ff    <= nxt_drv0;
      drv1_ff    <= nxt_drv1;
      en_ff      <= nxt_en;
      free_ff    <= nxt_free;
    end
  end

  assign o_sfr_rdata   = rdata_ff;
  assign o_sfr_hit     = hit_ff;
  assign o_chan0       = drv0_ff;
  assign o_chan1       = drv1_ff;
  assign o_out_en_four = en_ff[0];
  assign o_out_en_five = en_ff[1];
  assign o_input_free  = free_ff;

endmodule

// ===== rtl/conv_ctrl_cfg.svh
// Constants for the dual converter control block: SFR addresses,
// control bit positions, reset values and code widths.
// Assumes inclusion by the package and the design modules only.
//
// Behaviour
// - Two channels, 12-bit code each
// - Code right-justified, low byte plus high nibble
// - 12-bit mode transfers on low write
// - Mode bit set selects 8-bit mode
// - Span bit per channel selects range
// - Clear bit low forces zero output
// - Sync bit high updates on low write
// - Sync low holds; rising sync transfers both
// - Power bit per channel powers converter
// - Data reset 00H, control reset 04H
// - Data at F9H-FCH, control at FDH
// - Outputs share pins with inputs four, five
// - Outputs high impedance until enabled
`ifndef CONV_CTRL_CFG_SVH
`define CONV_CTRL_CFG_SVH

`define ADDR_CHAN0_LOW   8'hf9
`define ADDR_CHAN0_HIGH  8'hfa
`define ADDR_CHAN1_LOW   8'hfb
`define ADDR_CHAN1_HIGH  8'hfc
`define ADDR_CONTROL     8'hfd

`define DATA_RESET       8'h00
`define CONTROL_RESET    8'h04

`define BIT_MODE         7
`define BIT_SPAN1        6
`define BIT_SPAN0        5
`define BIT_ZERO1_N      4
`define BIT_ZERO0_N      3
`define BIT_SYNC         2
`define BIT_POWER1       1
`define BIT_POWER0       0

`define CODE_W           12
`define HIGH_NIBBLE_W    4
`define NUM_CHAN         2

`endif

// ===== rtl/conv_ctrl_pkg.sv
// Types shared by the converter control block.
// Assumes conv_ctrl_cfg.svh is reachable on the include path.
`include "conv_ctrl_cfg.svh"
package conv_ctrl_pkg;

  // Per-channel drive toward one converter core
  typedef struct packed {
    logic [`CODE_W-1:0] code;
    logic               span_supply;
    logic               zero_force_n;
    logic               power_on;
  } chan_drive_type;

endpackage

// ===== tb/conv_core_model.sv
// Converter core stand-in: drive struct to pin level.
// Assumes drive and pin enable come from conv_ctrl.
`timescale 1ns/1ps
module conv_core_model
  import conv_ctrl_pkg::*;
(
  input  wire chan_drive_type i_drive,
  input  wire logic           i_pin_en,
  output logic      [12:0]    o_level
);
  // Bit 12 is the span; pull-down holds an idle pin at ground
  always_comb
  begin
    if (!i_pin_en || !i_drive.power_on)
      o_level = 13'h0000;
    else if (!i_drive.zero_force_n)
      o_level = 13'h0000;
    else
      o_level = {i_drive.span_supply, i_drive.code};
  end
endmodule

// ===== tb/conv_ctrl_chk.sv
// Port checker for conv_ctrl.
// Assumes the bind below; sees top ports only.
`timescale 1ns/1ps
module conv_ctrl_chk
  import conv_ctrl_pkg::*;
(
  input wire logic           i_mclk,
  input wire logic           i_arst_n,
  input wire logic [7:0]     i_sfr_addr,
  input wire logic           i_sfr_wr,
  input wire logic [7:0]     i_sfr_wdata,
  input wire logic           i_sfr_rd,
  input wire logic [7:0]     o_sfr_rdata,
  input wire logic           o_sfr_hit,
  input wire chan_drive_type o_chan0,
  input wire chan_drive_type o_chan1,
  input wire logic           o_out_en_four,
  input wire logic           o_out_en_five,
  input wire logic [1:0]     o_input_free
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // Lone write: no write the cycle before, so no late effect overlaps
  sequence s_wr(logic [7:0] a);
    !$past(i_sfr_wr) && i_sfr_wr && i_sfr_addr == a;
  endsequence
  sequence s_ctl;
    i_sfr_wr && i_sfr_addr == 8'hfd;
  endsequence
  property p_pwr;
    logic [7:0] d;
    (s_ctl, d = i_sfr_wdata) |=> ##1 o_out_en_four == d[0] && o_out_en_five == d[1]
      && o_chan0.power_on == d[0] && o_chan1.power_on == d[1]
      && o_input_free == ~d[1:0];
  endproperty
  property p_span;
    logic [7:0] d;
    (s_ctl, d = i_sfr_wdata) |=> ##1 o_chan0.span_supply == d[5]
      && o_chan1.span_supply == d[6] && o_chan0.zero_force_n == d[3]
      && o_chan1.zero_force_n == d[4];
  endproperty
  a_rd_hit: assert property (i_sfr_rd && i_sfr_addr inside {[8'hf9:8'hfd]} |=> o_sfr_hit)
    else $error("mapped read gave no hit");
  a_rd_miss: assert property (i_sfr_rd && !(i_sfr_addr inside {[8'hf9:8'hfd]})
    |=> !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("unmapped read answered");
  a_power_en: assert property (p_pwr)
    else $error("enables miss power bits");
  a_span_clear: assert property (p_span)
    else $error("span or clear wrong");
  a_high_hold0: assert property (s_wr(8'hfa) |=> ##1 $stable(o_chan0.code))
    else $error("high write moved code 0");
  a_high_hold1: assert property (s_wr(8'hfc) |=> ##1 $stable(o_chan1.code))
    else $error("high write moved code 1");
  a_code_quiet: assert property (!i_sfr_wr |=> ##1 $stable({o_chan0.code, o_chan1.code}))
    else $error("code moved without write");
  a_reset_idle: assert property ($rose(i_arst_n) |-> o_input_free == 2'b11
    && !o_out_en_four && !o_out_en_five && o_chan0 == '0) else $error("bad reset state");
endmodule
bind conv_ctrl conv_ctrl_chk chk_u (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
  .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit),
  .o_chan0(o_chan0), .o_chan1(o_chan1), .o_out_en_four(o_out_en_four),
  .o_out_en_five(o_out_en_five), .o_input_free(o_input_free));

// ===== tb/conv_ctrl_tb.sv
// Testbench for conv_ctrl: SFR tasks plus two core models.
// Assumes 125 MHz clock and the SFR timing of the design.
`timescale 1ns/1ps
module conv_ctrl_tb;
  import conv_ctrl_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic hit, en4, en5;
  logic [1:0] free;
  chan_drive_type ch0, ch1;
  logic [12:0] lvl0, lvl1;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #4 mclk = ~mclk;
  conv_ctrl dut_u (.i_mclk(mclk), .i_arst_n(arst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .o_chan0(ch0), .o_chan1(ch1), .o_out_en_four(en4), .o_out_en_five(en5),
    .o_input_free(free));
  conv_core_model core0_u (.i_drive(ch0), .i_pin_en(en4), .o_level(lvl0));
  conv_core_model core1_u (.i_drive(ch1), .i_pin_en(en5), .o_level(lvl1));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read answer lands on the same edge that takes the request
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic eh);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk({hit, rdata}, {eh, e});
  endtask
  task automatic settle;
    @(posedge mclk);
    #1;
  endtask
  task automatic print_verdict;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard; the sequence needs about 55 cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    // Reset values and decode, both unmapped neighbours included
    for (int i = 0; i < 7; i++)
      rd_chk(8'hf8 + 8'(i), (i == 5) ? 8'h04 : 8'h00, 1'(i > 0 && i < 6));
    chk({ch0, ch1, en4, en5, free}, 32'h3);
    // Channel 1 on the reference span; the ADC reference is taken as up
    wr_reg(8'hfd, 8'h3f);
    settle;
    chk({en5, en4, free, ch0.span_supply, ch1.span_supply}, 6'b110010);
    wr_reg(8'hfa, 8'ha5);
    settle;
    chk(ch0.code, 12'h000);
    wr_reg(8'hf9, 8'h3c);
    settle;
    chk(lvl0, 13'h153c);
    rd_chk(8'hfa, 8'ha5, 1'b1);
    // Held writes, then one sync rise moves both channels together
    wr_reg(8'hfd, 8'h3b);
    wr_reg(8'hfc, 8'h07);
    wr_reg(8'hfb, 8'hff);
    wr_reg(8'hf9, 8'h11);
    settle;
    chk({ch1.code, ch0.code}, 24'h00053c);
    wr_reg(8'hfd, 8'h3f);
    #1;
    chk({ch1.code, ch0.code}, 24'h00053c);
    settle;
    chk({ch1.code, ch0.code}, 24'h7ff511);
    wr_reg(8'hfd, 8'hb7);
    wr_reg(8'hfb, 8'h9c);
    settle;
    chk({lvl1, lvl0}, {13'h09c0, 13'h0000});
    wr_reg(8'hfd, 8'h00);
    settle;
    chk({en4, en5, free, lvl0}, {4'h3, 13'h0000});
    // Unmapped write must leave the control register alone
    wr_reg(8'hfe, 8'hff);
    rd_chk(8'hfd, 8'h00, 1'b1);
    print_verdict;
  end
endmodule
